// >>> rtl/eer_core.sv
/*
  two-wire serial memory slave: control byte decode, word address, page
  buffer, self-timed write cycle with acknowledge polling, and current,
  random and sequential reads. assumes an open-drain data line resolved
  outside and a link clock that samples the bus lines.
*/
`timescale 1ns/1ps
`default_nettype none
module eer_core
  import eer_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
  parameter int PAGE_W = PAGE_BITS_DEF
) (
  // clocks and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic linkClk,
  // two-wire bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // straps
  input wire logic lockPin,
  input wire logic [CS_BITS-1:0] chipSelectBits
);

  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int PAGES = 1 << PAGE_W;
  localparam logic [TW-1:0] TMR_LOAD = TW'(WRITE_CYCLES);
  localparam logic [TW-1:0] TMR_LAST = TW'(1);

  typedef struct packed {
    logic [N_EV-1:0] tglMeta;
    logic [N_EV-1:0] tglSync;
    logic [N_EV-1:0] tglPrev;
    logic lockMeta;
    logic lockSync;
    logic [CS_BITS-1:0] csMeta;
    logic [CS_BITS-1:0] csSync;
    logic bitMeta;
    logic bitSync;
    eer_phase_e phase;
    logic [3:0] cnt;
    logic [DATA_BITS-1:0] shift;
    logic [DATA_BITS-1:0] tx;
    logic ackIn;
    logic [ADDR_BITS-1:0] ptr;
    logic [PAGES-1:0][DATA_BITS-1:0] buffer;
    logic [PAGES-1:0] valid;
    logic busy;
    logic [TW-1:0] timer;
    logic sdaOe;
    logic sdaOut;
    logic [DEPTH-1:0][DATA_BITS-1:0] mem;
  } eer_state_s;

  eer_state_s s;
  eer_state_s next_s;

  eer_link_if lnk ();

  eer_link_front u_front (
    .linkClk(linkClk),
    .arst_n(arst_n),
    .scl(scl),
    .sdaIn(sdaIn),
    .lnk(lnk.link)
  );

  logic [N_EV-1:0] ev;
  logic fallOnly;
  logic riseOnly;
  logic ctrlMatch;
  logic ackWanted;
  logic doneFall;
  logic readLoad;
  logic commitStop;

  // events cross as toggles; each stays put for microseconds
  assign ev = s.tglSync ^ s.tglPrev;
  assign riseOnly = ev[EV_RISE] && !ev[EV_STOP] && !ev[EV_START];
  assign fallOnly = ev[EV_FALL] && !ev[EV_STOP] && !ev[EV_START] && !ev[EV_RISE];
  assign ctrlMatch = (s.shift[CODE_HI:CODE_LO] == CTRL_CODE) && (s.shift[CS_HI:CS_LO] == s.csSync);
  assign doneFall = fallOnly && (s.cnt == BIT_DONE);
  assign commitStop = ev[EV_STOP] && (s.phase == PH_WDATA) && (|s.valid);

  // a busy device never acknowledges; polling relies on that
  always_comb begin
    ackWanted = 1'b0;
    if (s.phase == PH_CTRL) begin
      ackWanted = ctrlMatch && !s.busy;
    end else if (s.phase == PH_ADDR || s.phase == PH_WDATA) begin
      ackWanted = !s.busy;
    end
  end

  // the acknowledge we drove is the decision taken at the end of the slot
  always_comb begin
    readLoad = 1'b0;
    if (doneFall) begin
      if (s.phase == PH_CTRL) begin
        readLoad = s.sdaOe && s.shift[RW_BIT];
      end else if (s.phase == PH_RDATA) begin
        readLoad = !s.ackIn;
      end
    end
  end

  always_comb begin
    next_s = s;
    next_s.tglMeta = lnk.tgl;
    next_s.tglSync = s.tglMeta;
    next_s.tglPrev = s.tglSync;
    next_s.lockMeta = lockPin;
    next_s.lockSync = s.lockMeta;
    next_s.csMeta = chipSelectBits;
    next_s.csSync = s.csMeta;
    next_s.bitMeta = lnk.bitVal;
    next_s.bitSync = s.bitMeta;

    if (s.busy) begin
      next_s.timer = s.timer - TMR_LAST;
      if (s.timer == TMR_LAST) begin
        next_s.busy = 1'b0;
      end
    end

    // a stop and a start seen together: the stop is older and wins
    if (ev[EV_STOP]) begin
      next_s.phase = PH_IDLE;
      next_s.cnt = '0;
      next_s.sdaOe = 1'b0;
      next_s.valid = '0;
      if (commitStop) begin
        next_s.busy = 1'b1;
        next_s.timer = TMR_LOAD;
        for (int i = 0; i < PAGES; i++) begin
          if (s.valid[i] && !s.lockSync) begin
            next_s.mem[{s.ptr[ADDR_BITS-1:PAGE_W], PAGE_W'(i)}] = s.buffer[i];
          end
        end
      end
    end else if (ev[EV_START]) begin
      // restart discards buffered data but leaves the pointer alone
      next_s.phase = PH_CTRL;
      next_s.cnt = '0;
      next_s.sdaOe = 1'b0;
      next_s.valid = '0;
    end else if (riseOnly && s.phase != PH_IDLE) begin
      if (s.cnt < BIT_ACK) begin
        next_s.shift = {s.shift[DATA_BITS-2:0], s.bitSync};
        next_s.cnt = s.cnt + 4'h1;
      end else if (s.cnt == BIT_ACK) begin
        next_s.ackIn = s.bitSync;
        next_s.cnt = BIT_DONE;
      end
    end else if (fallOnly && s.phase != PH_IDLE) begin
      if (s.cnt == BIT_ACK) begin
        if (s.phase == PH_RDATA) begin
          next_s.sdaOe = 1'b0;
        end else begin
          next_s.sdaOe = ackWanted;
        end
      end else if (s.cnt == BIT_DONE) begin
        next_s.cnt = '0;
        next_s.sdaOe = 1'b0;
        unique case (s.phase)
          PH_IDLE: begin
            next_s.phase = PH_IDLE;
          end
          PH_CTRL: begin
            if (!s.sdaOe) begin
              next_s.phase = PH_IDLE;
            end else if (!s.shift[RW_BIT]) begin
              next_s.phase = PH_ADDR;
            end
          end
          PH_ADDR: begin
            next_s.ptr = s.shift;
            next_s.phase = PH_WDATA;
          end
          PH_WDATA: begin
            next_s.buffer[s.ptr[PAGE_W-1:0]] = s.shift;
            next_s.valid[s.ptr[PAGE_W-1:0]] = 1'b1;
            // only the low bits move; the page wraps on itself
            next_s.ptr = {s.ptr[ADDR_BITS-1:PAGE_W], s.ptr[PAGE_W-1:0] + PAGE_W'(1)};
          end
          PH_RDATA: begin
            if (s.ackIn) begin
              next_s.phase = PH_IDLE;
            end
          end
        endcase
        if (readLoad) begin
          next_s.phase = PH_RDATA;
          next_s.tx = s.mem[s.ptr];
          next_s.sdaOe = !s.mem[s.ptr][DATA_BITS-1];
          next_s.ptr = eerIncr(s.ptr);
        end
      end else if (s.phase == PH_RDATA && s.cnt != '0) begin
        next_s.tx = {s.tx[DATA_BITS-2:0], 1'b0};
        next_s.sdaOe = !s.tx[DATA_BITS-2];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sdaOe = s.sdaOe;
  assign sdaOut = s.sdaOut;

  property p_lockHolds;
    @(posedge clk) disable iff (!arst_n)
      s.lockSync |=> $stable(s.mem);
  endproperty
  a_lockHolds: assert property (p_lockHolds) else $error("memory changed while locked");

  property p_unlockedCommit;
    @(posedge clk) disable iff (!arst_n)
      (commitStop && s.valid[0] && !s.lockSync)
        |=> s.mem[{$past(s.ptr[ADDR_BITS-1:PAGE_W]), {PAGE_W{1'b0}}}] == $past(s.buffer[0]);
  endproperty
  a_unlockedCommit: assert property (p_unlockedCommit) else $error("unlocked write lost");

  property p_busyNoAck;
    @(posedge clk) disable iff (!arst_n)
      (s.busy && s.phase == PH_CTRL && fallOnly && s.cnt == BIT_ACK) |=> !s.sdaOe [*2];
  endproperty
  a_busyNoAck: assert property (p_busyNoAck) else $error("acknowledge while busy");

  property p_stopStartsCycle;
    @(posedge clk) disable iff (!arst_n)
      commitStop |=> s.busy && (s.timer == TMR_LOAD);
  endproperty
  a_stopStartsCycle: assert property (p_stopStartsCycle) else $error("write cycle not started");

  property p_cycleEnds;
    @(posedge clk) disable iff (!arst_n)
      (s.busy && s.timer == TMR_LAST) |=> !s.busy && (s.timer == '0);
  endproperty
  a_cycleEnds: assert property (p_cycleEnds) else $error("write cycle did not end");

  property p_readLoad;
    @(posedge clk) disable iff (!arst_n)
      readLoad |=> (s.ptr == eerIncr($past(s.ptr))) && (s.tx == s.mem[$past(s.ptr)])
        && (s.sdaOe == !s.tx[DATA_BITS-1]) && (s.phase == PH_RDATA);
  endproperty
  a_readLoad: assert property (p_readLoad) else $error("read byte or pointer wrong");

  property p_ptrWrap;
    @(posedge clk) disable iff (!arst_n)
      (readLoad && s.ptr == '1) |=> (s.ptr == '0);
  endproperty
  a_ptrWrap: assert property (p_ptrWrap) else $error("pointer did not wrap");

  property p_ctrlMatch;
    @(posedge clk) disable iff (!arst_n)
      (s.phase == PH_CTRL && s.cnt == BIT_DONE && s.sdaOe)
        |-> (s.shift[CODE_HI:CODE_LO] == CTRL_CODE) && (s.shift[CS_HI:CS_LO] == s.csSync) && !s.busy;
  endproperty
  a_ctrlMatch: assert property (p_ctrlMatch) else $error("foreign control byte acknowledged");

  property p_dataAck;
    @(posedge clk) disable iff (!arst_n)
      (fallOnly && s.cnt == BIT_ACK && s.phase == PH_WDATA) |=> s.sdaOe;
  endproperty
  a_dataAck: assert property (p_dataAck) else $error("data byte not acknowledged");

  property p_restartKeepsPtr;
    @(posedge clk) disable iff (!arst_n)
      (ev[EV_START] && !ev[EV_STOP] && s.phase == PH_WDATA)
        |=> (s.valid == '0) && $stable(s.ptr) && $stable(s.mem) && !s.busy;
  endproperty
  a_restartKeepsPtr: assert property (p_restartKeepsPtr) else $error("restart disturbed write state");

  property p_nackReleases;
    @(posedge clk) disable iff (!arst_n)
      (doneFall && s.phase == PH_RDATA && s.ackIn) |=> (!s.sdaOe && s.phase == PH_IDLE) [*4];
  endproperty
  a_nackReleases: assert property (p_nackReleases) else $error("line held after master nack");

  property p_msbFirst;
    @(posedge clk) disable iff (!arst_n)
      (fallOnly && s.phase == PH_RDATA && s.cnt != '0 && s.cnt < BIT_ACK)
        |=> (s.sdaOe == !$past(s.tx[DATA_BITS-2])) && (s.tx == {$past(s.tx[DATA_BITS-2:0]), 1'b0});
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("read bit order wrong");

  property p_stopReleases;
    @(posedge clk) disable iff (!arst_n)
      ev[EV_STOP] |=> !s.sdaOe && (s.phase == PH_IDLE) && (s.valid == '0);
  endproperty
  a_stopReleases: assert property (p_stopReleases) else $error("stop did not release the line");

  property p_lockedCycle;
    @(posedge clk) disable iff (!arst_n)
      (commitStop && s.lockSync) |=> s.busy && $stable(s.mem);
  endproperty
  a_lockedCycle: assert property (p_lockedCycle) else $error("locked write stored or skipped cycle");

  property p_seqNext;
    @(posedge clk) disable iff (!arst_n)
      (doneFall && s.phase == PH_RDATA && !s.ackIn)
        |=> (s.phase == PH_RDATA) && (s.ptr == eerIncr($past(s.ptr)));
  endproperty
  a_seqNext: assert property (p_seqNext) else $error("acknowledged read did not advance");

  // idle means released; a stray slot must never pull the line
  property p_idleQuiet;
    @(posedge clk) disable iff (!arst_n)
      (s.phase == PH_IDLE) |-> !s.sdaOe;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("line driven while idle");

  property p_pageStore;
    @(posedge clk) disable iff (!arst_n)
      (doneFall && s.phase == PH_WDATA)
        |=> (s.ptr[ADDR_BITS-1:PAGE_W] == $past(s.ptr[ADDR_BITS-1:PAGE_W]))
          && (s.buffer[$past(s.ptr[PAGE_W-1:0])] == $past(s.shift)) && !s.busy;
  endproperty
  a_pageStore: assert property (p_pageStore) else $error("data byte not buffered");

  property p_addrTaken;
    @(posedge clk) disable iff (!arst_n)
      (doneFall && s.phase == PH_ADDR) |=> (s.ptr == $past(s.shift)) && (s.phase == PH_WDATA);
  endproperty
  a_addrTaken: assert property (p_addrTaken) else $error("word address not taken");

  property p_busyQuiet;
    @(posedge clk) disable iff (!arst_n)
      (s.busy && fallOnly && s.cnt == BIT_ACK) |=> !s.sdaOe;
  endproperty
  a_busyQuiet: assert property (p_busyQuiet) else $error("acknowledge slot driven while busy");

endmodule // eer_core
`default_nettype wire

// >>> rtl/eer_link_front.sv
/*
  link-clock front end: synchronises the bus lines and turns start, stop
  and clock edges into toggles. assumes the link clock is much faster than
  the serial clock so that no edge is missed.
*/
`timescale 1ns/1ps
`default_nettype none
module eer_link_front
  import eer_pkg::*;
(
  // link clock and reset
  input wire logic linkClk,
  input wire logic arst_n,
  // bus lines as seen on the wire
  input wire logic scl,
  input wire logic sdaIn,
  // events toward the core
  eer_link_if.link lnk
);

  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    logic [N_EV-1:0] tgl;
    logic bitVal;
  } eer_front_s;

  // lines leave reset at their idle level, so no false edge follows reset
  localparam eer_front_s FRONT_IDLE = '{sclMeta: 1'b1, sclSync: 1'b1, sclPrev: 1'b1, sdaMeta: 1'b1, sdaSync: 1'b1,
    sdaPrev: 1'b1, tgl: '0, bitVal: 1'b1};

  eer_front_s s;
  eer_front_s n;
  logic startCond;
  logic stopCond;

  assign startCond = s.sclSync && s.sclPrev && s.sdaPrev && !s.sdaSync;
  assign stopCond = s.sclSync && s.sclPrev && !s.sdaPrev && s.sdaSync;

  always_comb begin
    n = s;
    n.sclMeta = scl;
    n.sclSync = s.sclMeta;
    n.sclPrev = s.sclSync;
    n.sdaMeta = sdaIn;
    n.sdaSync = s.sdaMeta;
    n.sdaPrev = s.sdaSync;
    // data edges while the clock is high are conditions, not bits
    if (startCond) begin
      n.tgl[EV_START] = !s.tgl[EV_START];
    end
    if (stopCond) begin
      n.tgl[EV_STOP] = !s.tgl[EV_STOP];
    end
    // the level runs ahead of the rise toggle, so the core's synchroniser has settled before it is read
    n.bitVal = s.sdaSync;
    if (s.sclSync && !s.sclPrev) begin
      n.tgl[EV_RISE] = !s.tgl[EV_RISE];
    end
    if (!s.sclSync && s.sclPrev) begin
      n.tgl[EV_FALL] = !s.tgl[EV_FALL];
    end
  end

  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      s <= FRONT_IDLE;
    end else begin
      s <= n;
    end
  end

  assign lnk.tgl = s.tgl;
  assign lnk.bitVal = s.bitVal;

  property p_startToggle;
    @(posedge linkClk) disable iff (!arst_n)
      startCond |=> s.tgl[EV_START] != $past(s.tgl[EV_START]);
  endproperty
  a_startToggle: assert property (p_startToggle) else $error("start not signalled");

endmodule // eer_link_front
`default_nettype wire

// >>> rtl/eer_link_if.sv
/*
  event carrier from the link-clock front end to the system-clock core.
  assumes each toggle is read through a two-stage synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
interface eer_link_if;
  import eer_pkg::*;
  logic [N_EV-1:0] tgl;
  logic bitVal;
  modport link (output tgl, output bitVal);
  modport core (input tgl, input bitVal);
endinterface
`default_nettype wire

// >>> rtl/eer_pkg.sv
/*
  constants, types and helpers shared by the serial memory slave.
  assumes a 40 MHz system clock and a separate link sampling clock.
*/
package eer_pkg;

  localparam int CLK_PERIOD_NS = 25;
  // write cycle length; arbitrary default, shortened in simulation
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES_DEF = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int PAGE_BITS_DEF = 4;
  localparam int CS_BITS = 3;

  // control byte layout
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 4;
  localparam int CS_HI = 3;
  localparam int CS_LO = 1;
  localparam int RW_BIT = 0;

  // bit counter: eight data clocks, then the acknowledge clock
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // link event toggles
  localparam int N_EV = 4;
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_RISE = 2;
  localparam int EV_FALL = 3;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CTRL,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA
  } eer_phase_e;

  function automatic logic [ADDR_BITS-1:0] eerIncr(input logic [ADDR_BITS-1:0] a);
    return a + 1'b1;
  endfunction

endpackage

// >>> tb/eer_master.sv
/*
  two-wire bus master model: start, stop, byte send and byte receive.
  assumes an open-drain data line resolved by the bench, pulled high.
*/
`timescale 1ns/1ps
`default_nettype none
module eer_master
  import eer_pkg::*;
#(
  parameter int HALF = 60
) (
  // system clock paces the bus
  input wire logic clk,
  // bus lines
  input wire logic sdaIn,
  output logic scl,
  output logic mOe
);
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    mOe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // also serves as repeated start
  task automatic start();
    mOe <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    mOe <= 1'b1;
    wt(HALF);
    scl <= 1'b0;
  endtask

  task automatic stop();
    mOe <= 1'b1;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    mOe <= 1'b0;
    wt(HALF);
  endtask

  // data set in the low phase and held well past the sampling rise
  task automatic bitIo(input logic b, output logic r);
    mOe <= ~b;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF / 2);
    r = sdaIn;
    wt(HALF / 2);
    scl <= 1'b0;
    wt(1);
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], r);
    end
    bitIo(1'b1, r);
    ack = ~r;
  endtask

  // ack requests the next byte, a released slot ends the read
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(~ackIt, r);
  endtask
endmodule // eer_master
`default_nettype wire

// >>> tb/test_eer_core.sv
/*
  self-checking bench for the serial memory slave: write, polling, lock,
  reads and chip select. assumes the master model drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module test_eer_core;
  import eer_pkg::*;
  // long enough that the first poll after a write is refused
  localparam int WCYC = 2000;
  localparam logic [2:0] CSEL = 3'h5;
  logic clk, linkClk, arst_n, lockPin, scl, mOe, sdaOut, sdaOe, sdaIn;
  logic [CS_BITS-1:0] chipSelectBits;
  int n_fail, num_checks;

  // open drain: a driven line shows the device's drive value, otherwise the pull-up
  assign sdaIn = (sdaOe ? sdaOut : 1'b1) && !mOe;

  eer_core #(.WRITE_CYCLES(WCYC), .PAGE_W(4)) u_eer_core (.clk(clk), .arst_n(arst_n), .linkClk(linkClk),
    .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .lockPin(lockPin),
    .chipSelectBits(chipSelectBits));
  eer_master #(.HALF(60)) u_eer_master (.clk(clk), .sdaIn(sdaIn), .scl(scl), .mOe(mOe));

  always #12.5 clk = ~clk;
  initial begin
    linkClk = 1'b0;
    #3;
    forever #40 linkClk = ~linkClk;
  end

  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic rd);
    return {CTRL_CODE, cs, rd};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic wrPage(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
    logic ack;
    u_eer_master.start();
    u_eer_master.sendByte(ctl(CSEL, 1'b0), ack);
    chk({7'h00, ack}, 8'h01);
    u_eer_master.sendByte(a, ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_eer_master.sendByte(i == 0 ? d0 : d1, ack);
      chk({7'h00, ack}, 8'h01);
    end
    u_eer_master.stop();
  endtask

  // a poll that never gets an answer ends the run
  task automatic poll(output int tries);
    logic ack;
    tries = 0;
    ack = 1'b0;
    while (ack !== 1'b1 && tries < 8) begin
      tries++;
      u_eer_master.start();
      u_eer_master.sendByte(ctl(CSEL, 1'b0), ack);
      u_eer_master.stop();
    end
    if (ack !== 1'b1) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      n_fail++;
      stop_test();
    end
  endtask

  task automatic rdSeq(input logic rnd, input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1,
                       input int n);
    logic ack;
    logic [7:0] d;
    u_eer_master.start();
    if (rnd) begin
      u_eer_master.sendByte(ctl(CSEL, 1'b0), ack);
      u_eer_master.sendByte(a, ack);
      u_eer_master.start();
    end
    u_eer_master.sendByte(ctl(CSEL, 1'b1), ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_eer_master.readByte(i < n - 1, d);
      chk(d, i == 0 ? e0 : e1);
    end
    u_eer_master.stop();
    chk({7'h00, sdaOe}, 8'h00);
  endtask

  task automatic scnWrapRead();
    int tries;
    wrPage(8'hFF, 8'h5A, 8'h00, 1);
    poll(tries);
    chk({7'h00, tries > 1}, 8'h01);
    chk({7'h00, tries <= 3}, 8'h01);
    wrPage(8'h00, 8'hC3, 8'h96, 2);
    poll(tries);
    rdSeq(1'b1, 8'hFF, 8'h5A, 8'hC3, 2);
    rdSeq(1'b0, 8'h00, 8'h96, 8'h00, 1);
    rdSeq(1'b1, 8'h01, 8'h96, 8'h00, 1);
    poll(tries);
    chk(tries[7:0], 8'h01);
  endtask

  task automatic scnLock();
    int tries;
    lockPin <= 1'b1;
    wrPage(8'h10, 8'hA5, 8'h00, 1);
    poll(tries);
    chk({7'h00, tries > 1}, 8'h01);
    rdSeq(1'b1, 8'h10, 8'h00, 8'h00, 1);
    lockPin <= 1'b0;
  endtask

  // only the strapped select and the fixed code are answered
  task automatic scnSelect();
    logic ack;
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      u_eer_master.start();
      u_eer_master.sendByte(i == 8 ? {4'h5, CSEL, 1'b1} : ctl(i[2:0], 1'b1), ack);
      chk({7'h00, ack}, {7'h00, i == int'(CSEL)});
      if (ack === 1'b1) begin
        u_eer_master.readByte(1'b0, d);
        chk(d, 8'h00);
      end
      u_eer_master.stop();
    end
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    lockPin = 1'b0;
    chipSelectBits = CSEL;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (40) @(posedge clk);
    scnWrapRead();
    scnLock();
    scnSelect();
    stop_test();
  end
endmodule // test_eer_core
`default_nettype wire
